// *** hw/swt_consts.svh ***
// Register map, field positions and timing constants of the sleep/wake timer control
`ifndef SWT_CONSTS_SVH
`define SWT_CONSTS_SVH

`define SWT_ADDR_IRQ_CTRL   8'hA1
`define SWT_ADDR_CTRL       8'hA2

`define SWT_BIT_E1_EN       5
`define SWT_BIT_E0_EN       4
`define SWT_BIT_E1_PEND     1
`define SWT_BIT_E0_PEND     0

`define SWT_DLY_MSB         6
`define SWT_DLY_LSB         4
`define SWT_BIT_CLR         2
`define SWT_RES_MSB         1
`define SWT_RES_LSB         0

`define SWT_DLY_RST         3'h7
`define SWT_RES_RST         2'h0
`define SWT_RDATA_RST       8'h00

`define SWT_DLY_C0          6'h04
`define SWT_DLY_C1          6'h06
`define SWT_DLY_C2          6'h08
`define SWT_DLY_C3          6'h0C
`define SWT_DLY_C4          6'h10
`define SWT_DLY_C5          6'h18
`define SWT_DLY_C6          6'h20
`define SWT_DLY_C7          6'h30

`define SWT_SLOW_DIV        750
`define SWT_RES_SHIFT       5
`define SWT_CNT_W           31
`define SWT_VIEW_W          16
`define SWT_PERIOD_W        16
`define SWT_DLY_CNT_W       6

`endif

// *** hw/swt_pkg.sv ***
// Types shared by the sleep/wake timer control files
package swt_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } swt_sfr_req_type;

    typedef enum logic [0:0] {
        SWT_DLY_IDLE = 1'b0,
        SWT_DLY_WAIT = 1'b1
    } swt_dly_state_type;

    typedef enum logic [1:0] {
        SWT_RES_31US = 2'b00,
        SWT_RES_1MS  = 2'b01,
        SWT_RES_32MS = 2'b10,
        SWT_RES_1S   = 2'b11
    } swt_res_type;

endpackage

// *** hw/swt_slow_tick.sv ***
// Divider that turns the main clock into the slow timer tick enable
`include "swt_consts.svh"

module swt_slow_tick import swt_pkg::*; #(
    parameter int DIV = `SWT_SLOW_DIV
) (
    input  wire logic MCLK,
    input  wire logic RST_N,
    output logic      tick
);

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    if (DIV < 2) begin : g_bad_div
        $error("swt_slow_tick: DIV must be at least 2");
    end

    logic [CW-1:0] div_r;
    logic [CW-1:0] div_nxt;
    logic          tick_r;
    logic          tick_nxt;

    always_comb begin
        div_nxt  = div_r + CW'(1);
        tick_nxt = 1'b0;
        if (div_r == LAST) begin
            div_nxt  = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            div_r  <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

    // Ticks come exactly DIV main cycles apart
    AST_TICK_SPACING: assert property (@(posedge MCLK) disable iff (!RST_N)
        tick_r |-> $past(div_r) == LAST)
        else $error("slow tick not aligned to divider wrap");

endmodule

// *** hw/swt_top.sv ***
// Sleep/wake timer control: counter, event timing, pending flags and SFR access
// Notes on behaviour
// - Delay field, reset 111, picks 4,6,8,12,16,24,32,48 slow cycles to second event.
// - Slow timer clock is the main clock divided by 750.
// - Writing one to control bit 2 clears the sleep counter.
// - Writing zero to the clear bit does nothing; it always reads zero.
// - Resolution code picks counter bits 15:0, 20:5, 25:10 or 30:15 as view.
// - Changing resolution leaves the underlying counter untouched.
// - Interrupt control bit 5 enables the second-event interrupt, reset zero.
// - Interrupt control bit 4 enables the first-event interrupt, reset zero.
// - Bit 1 shows second event pending; cleared by writing zero; reset zero.
// - Bit 0 shows first event pending; cleared by writing zero; reset zero.
// - Sleep timer is a 31-bit counter advanced by the slow tick.
// - First event period is mantissa times two to five times resolution ticks.
// - Second event follows a first event after the programmed delay; a newer first event or a clear restarts or cancels it.
// - Events set own pending flags; interrupt raised only for enabled flags.
`include "swt_consts.svh"

module swt_top import swt_pkg::*; #(
    parameter int CNT_W    = `SWT_CNT_W,
    parameter int SLOW_DIV = `SWT_SLOW_DIV
) (
    input  wire logic                     MCLK,
    input  wire logic                     RST_N,
    input  wire swt_sfr_req_type          SFR_REQ,
    output logic [7:0]                    SFR_RDATA,
    input  wire logic [`SWT_PERIOD_W-1:0] FIRST_EVENT_PERIOD,
    output logic [`SWT_VIEW_W-1:0]        TIMER_VIEW,
    output logic                          FIRST_EVENT,
    output logic                          SECOND_EVENT,
    output logic                          SLEEP_TIMER_IRQ
);

    if (CNT_W < `SWT_VIEW_W + 3 * `SWT_RES_SHIFT) begin : g_bad_cnt
        $error("swt_top: CNT_W too narrow for the widest resolution window");
    end

    function automatic logic [`SWT_DLY_CNT_W-1:0] dly_cycles(input logic [2:0] code);
        logic [`SWT_DLY_CNT_W-1:0] n;
        n = `SWT_DLY_C0;
        case (code)
            3'h0: n = `SWT_DLY_C0;
            3'h1: n = `SWT_DLY_C1;
            3'h2: n = `SWT_DLY_C2;
            3'h3: n = `SWT_DLY_C3;
            3'h4: n = `SWT_DLY_C4;
            3'h5: n = `SWT_DLY_C5;
            3'h6: n = `SWT_DLY_C6;
            default: n = `SWT_DLY_C7;
        endcase
        return n;
    endfunction

    logic tick;

    swt_slow_tick #(
        .DIV (SLOW_DIV)
    ) u_tick (
        .MCLK  (MCLK),
        .RST_N (RST_N),
        .tick  (tick)
    );

    // Bus decode
    logic wr_irq;
    logic wr_ctrl;
    logic timer_clr;

    always_comb begin
        wr_irq  = 1'b0;
        wr_ctrl = 1'b0;
        if (SFR_REQ.addr == `SWT_ADDR_IRQ_CTRL) begin
            wr_irq = SFR_REQ.wr;
        end else if (SFR_REQ.addr == `SWT_ADDR_CTRL) begin
            wr_ctrl = SFR_REQ.wr;
        end
    end

    // Clear is a pulse only, nothing is stored for it
    assign timer_clr = wr_ctrl && SFR_REQ.wdata[`SWT_BIT_CLR];

    // Configuration group
    logic [2:0]  dly_r;
    logic [2:0]  dly_nxt;
    swt_res_type res_r;
    swt_res_type res_nxt;
    logic        e1_en_r;
    logic        e1_en_nxt;
    logic        e0_en_r;
    logic        e0_en_nxt;

    always_comb begin
        dly_nxt   = dly_r;
        res_nxt   = res_r;
        e1_en_nxt = e1_en_r;
        e0_en_nxt = e0_en_r;
        if (wr_ctrl) begin
            dly_nxt = SFR_REQ.wdata[`SWT_DLY_MSB:`SWT_DLY_LSB];
            res_nxt = swt_res_type'(SFR_REQ.wdata[`SWT_RES_MSB:`SWT_RES_LSB]);
        end
        if (wr_irq) begin
            e1_en_nxt = SFR_REQ.wdata[`SWT_BIT_E1_EN];
            e0_en_nxt = SFR_REQ.wdata[`SWT_BIT_E0_EN];
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            dly_r   <= `SWT_DLY_RST;
            res_r   <= swt_res_type'(`SWT_RES_RST);
            e1_en_r <= 1'b0;
            e0_en_r <= 1'b0;
        end else begin
            dly_r   <= dly_nxt;
            res_r   <= res_nxt;
            e1_en_r <= e1_en_nxt;
            e0_en_r <= e0_en_nxt;
        end
    end

    // Window shift shared by the view and the first-event period
    logic [4:0] win_shift;

    always_comb begin
        case (res_r)
            SWT_RES_31US: win_shift = 5'(0 * `SWT_RES_SHIFT);
            SWT_RES_1MS:  win_shift = 5'(1 * `SWT_RES_SHIFT);
            SWT_RES_32MS: win_shift = 5'(2 * `SWT_RES_SHIFT);
            default:      win_shift = 5'(3 * `SWT_RES_SHIFT);
        endcase
    end

    // Counter and event group
    logic [CNT_W-1:0]          cnt_r;
    logic [CNT_W-1:0]          cnt_nxt;
    logic [CNT_W-1:0]          e0_cnt_r;
    logic [CNT_W-1:0]          e0_cnt_nxt;
    logic [CNT_W-1:0]          e0_limit;
    swt_dly_state_type         dly_state_r;
    swt_dly_state_type         dly_state_nxt;
    logic [`SWT_DLY_CNT_W-1:0] dly_cnt_r;
    logic [`SWT_DLY_CNT_W-1:0] dly_cnt_nxt;
    logic [`SWT_VIEW_W-1:0]    view_r;
    logic [`SWT_VIEW_W-1:0]    view_nxt;
    logic                      fire0;
    logic                      fire1;
    logic                      ev0_r;
    logic                      ev1_r;

    assign e0_limit = CNT_W'(FIRST_EVENT_PERIOD) << win_shift;

    always_comb begin
        cnt_nxt       = cnt_r;
        e0_cnt_nxt    = e0_cnt_r;
        dly_state_nxt = dly_state_r;
        dly_cnt_nxt   = dly_cnt_r;
        fire0         = 1'b0;
        fire1         = 1'b0;
        // The count update does not look at resolution, so changing it never disturbs the count
        if (timer_clr) begin
            cnt_nxt       = '0;
            e0_cnt_nxt    = '0;
            dly_state_nxt = SWT_DLY_IDLE;
        end else if (tick) begin
            cnt_nxt = cnt_r + CNT_W'(1);
            // A zero mantissa would mean no period, so it never fires
            if (e0_limit != '0 && e0_cnt_r + CNT_W'(1) >= e0_limit) begin
                fire0      = 1'b1;
                e0_cnt_nxt = '0;
            end else begin
                e0_cnt_nxt = e0_cnt_r + CNT_W'(1);
            end
            case (dly_state_r)
                SWT_DLY_IDLE: begin
                    dly_state_nxt = SWT_DLY_IDLE;
                end
                SWT_DLY_WAIT: begin
                    if (dly_cnt_r == `SWT_DLY_CNT_W'(1)) begin
                        fire1         = 1'b1;
                        dly_state_nxt = SWT_DLY_IDLE;
                    end else begin
                        dly_cnt_nxt = dly_cnt_r - `SWT_DLY_CNT_W'(1);
                    end
                end
                default: begin
                    dly_state_nxt = SWT_DLY_IDLE;
                end
            endcase
            // A new first event restarts the delay, even mid-wait
            if (fire0) begin
                dly_state_nxt = SWT_DLY_WAIT;
                dly_cnt_nxt   = dly_cycles(dly_r);
            end
        end
        view_nxt = `SWT_VIEW_W'(cnt_r >> win_shift);
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            cnt_r       <= '0;
            e0_cnt_r    <= '0;
            dly_state_r <= SWT_DLY_IDLE;
            dly_cnt_r   <= '0;
            view_r      <= '0;
            ev0_r       <= 1'b0;
            ev1_r       <= 1'b0;
        end else begin
            cnt_r       <= cnt_nxt;
            e0_cnt_r    <= e0_cnt_nxt;
            dly_state_r <= dly_state_nxt;
            dly_cnt_r   <= dly_cnt_nxt;
            view_r      <= view_nxt;
            ev0_r       <= fire0;
            ev1_r       <= fire1;
        end
    end

    // Pending flag group
    logic p0_r;
    logic p0_nxt;
    logic p1_r;
    logic p1_nxt;

    always_comb begin
        p0_nxt = p0_r;
        p1_nxt = p1_r;
        // Writing one keeps the flag; the event is ORed last so it wins
        if (wr_irq && !SFR_REQ.wdata[`SWT_BIT_E0_PEND]) begin
            p0_nxt = 1'b0;
        end
        if (wr_irq && !SFR_REQ.wdata[`SWT_BIT_E1_PEND]) begin
            p1_nxt = 1'b0;
        end
        p0_nxt = p0_nxt | fire0;
        p1_nxt = p1_nxt | fire1;
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            p0_r <= 1'b0;
            p1_r <= 1'b0;
        end else begin
            p0_r <= p0_nxt;
            p1_r <= p1_nxt;
        end
    end

    // Read data group
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    always_comb begin
        rdata_nxt = rdata_r;
        if (SFR_REQ.rd) begin
            rdata_nxt = `SWT_RDATA_RST;
            if (SFR_REQ.addr == `SWT_ADDR_IRQ_CTRL) begin
                rdata_nxt[`SWT_BIT_E1_EN]   = e1_en_r;
                rdata_nxt[`SWT_BIT_E0_EN]   = e0_en_r;
                rdata_nxt[`SWT_BIT_E1_PEND] = p1_r;
                rdata_nxt[`SWT_BIT_E0_PEND] = p0_r;
            end else if (SFR_REQ.addr == `SWT_ADDR_CTRL) begin
                rdata_nxt[`SWT_DLY_MSB:`SWT_DLY_LSB] = dly_r;
                rdata_nxt[`SWT_RES_MSB:`SWT_RES_LSB] = res_r;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            rdata_r <= `SWT_RDATA_RST;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign SFR_RDATA       = rdata_r;
    assign TIMER_VIEW      = view_r;
    assign FIRST_EVENT     = ev0_r;
    assign SECOND_EVENT    = ev1_r;
    assign SLEEP_TIMER_IRQ = (p0_r & e0_en_r) | (p1_r & e1_en_r);

    // Helper for checking: ticks seen since the last first event and its delay code
    logic [7:0] hlp_ticks_r;
    logic [2:0] hlp_dly_r;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            hlp_ticks_r <= '0;
            hlp_dly_r   <= `SWT_DLY_RST;
        end else if (fire0) begin
            hlp_ticks_r <= '0;
            hlp_dly_r   <= dly_r;
        end else if (tick && hlp_ticks_r != 8'hFF) begin
            hlp_ticks_r <= hlp_ticks_r + 8'h01;
        end
    end

    AST_E1_DELAY: assert property (@(posedge MCLK) disable iff (!RST_N)
        fire1 |-> (hlp_ticks_r + 8'h01) == {2'h0, dly_cycles(hlp_dly_r)})
        else $error("second event not at programmed delay");

    AST_CLR_ZEROES: assert property (@(posedge MCLK) disable iff (!RST_N)
        timer_clr |=> cnt_r == '0 && dly_state_r == SWT_DLY_IDLE)
        else $error("timer clear did not reset counter");

    AST_CLR_READS_ZERO: assert property (@(posedge MCLK) disable iff (!RST_N)
        SFR_REQ.rd && SFR_REQ.addr == `SWT_ADDR_CTRL |=> !SFR_RDATA[`SWT_BIT_CLR])
        else $error("clear bit read back as one");

    AST_RES_KEEPS_CNT: assert property (@(posedge MCLK) disable iff (!RST_N)
        wr_ctrl && !timer_clr && !tick |=> cnt_r == $past(cnt_r))
        else $error("control write disturbed the counter");

    AST_VIEW_WINDOW: assert property (@(posedge MCLK) disable iff (!RST_N)
        res_r == SWT_RES_1S && $stable(res_r) ##1 $stable(res_r)
        |-> TIMER_VIEW == $past(cnt_r[CNT_W-1:CNT_W-`SWT_VIEW_W]))
        else $error("view window wrong for coarsest resolution");

    AST_MASK_WRITE: assert property (@(posedge MCLK) disable iff (!RST_N)
        wr_irq |=> {e1_en_r, e0_en_r} ==
            $past(SFR_REQ.wdata[`SWT_BIT_E1_EN:`SWT_BIT_E0_EN]))
        else $error("enable bits did not take written value");

    AST_FLAG_SET: assert property (@(posedge MCLK) disable iff (!RST_N)
        (fire0 |=> p0_r) and (fire1 |=> p1_r))
        else $error("event did not set its pending flag");

    AST_SET_BEATS_CLR: assert property (@(posedge MCLK) disable iff (!RST_N)
        fire1 && wr_irq && !SFR_REQ.wdata[`SWT_BIT_E1_PEND] |=> p1_r)
        else $error("clear beat a coinciding second event");

    AST_IRQ_GATE: assert property (@(posedge MCLK) disable iff (!RST_N)
        SLEEP_TIMER_IRQ |-> (p0_r && e0_en_r) || (p1_r && e1_en_r))
        else $error("interrupt raised without enabled pending flag");

    AST_UNUSED_ZERO: assert property (@(posedge MCLK) disable iff (!RST_N)
        SFR_REQ.rd && SFR_REQ.addr == `SWT_ADDR_IRQ_CTRL
        |=> SFR_RDATA[7:6] == 2'h0 && SFR_RDATA[3:2] == 2'h0)
        else $error("unused interrupt control bits read nonzero");

    AST_TICK_ADVANCE: assert property (@(posedge MCLK) disable iff (!RST_N)
        tick && !timer_clr |=> cnt_r == $past(cnt_r) + CNT_W'(1))
        else $error("counter did not advance on slow tick");

endmodule

// *** dv/swt_top_bench.sv ***
// Self-checking bench for the sleep/wake timer control block
`include "swt_consts.svh"

module swt_top_bench import swt_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int DIV = 8;

    logic            mclk;
    logic            rst_n;
    swt_sfr_req_type req;
    logic [7:0]      rdata;
    logic [15:0]     period;
    logic [15:0]     view;
    logic            ev0;
    logic            ev1;
    logic            irq;
    int              fails;
    int              n_tests;

    // Short divider keeps the run small; every timing expectation scales with DIV
    swt_top #(.CNT_W(31), .SLOW_DIV(DIV)) i_swt_top (
        .MCLK               (mclk),
        .RST_N              (rst_n),
        .SFR_REQ            (req),
        .SFR_RDATA          (rdata),
        .FIRST_EVENT_PERIOD (period),
        .TIMER_VIEW         (view),
        .FIRST_EVENT        (ev0),
        .SECOND_EVENT       (ev1),
        .SLEEP_TIMER_IRQ    (irq)
    );

    initial mclk = 1'b0;
    always #2 mclk = ~mclk;

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (exp !== got) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        req.addr  = a;
        req.wdata = d;
        req.wr    = 1'b1;
        @(negedge mclk);
        req.wr    = 1'b0;
    endtask

    // Read data holds until the next read, so one spare cycle is safe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        req.addr = a;
        req.rd   = 1'b1;
        @(negedge mclk);
        req.rd   = 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask

    // 0: first event, 1: second event, 2: any change of the view
    task automatic wait_for(input int sel, output int c);
        logic [15:0] v;
        logic        hit;
        v = view;
        c = 0;
        hit = 1'b0;
        while (!hit) begin
            @(negedge mclk);
            c++;
            if (sel == 0) hit = (ev0 === 1'b1);
            else if (sel == 1) hit = (ev1 === 1'b1);
            else hit = (view !== v);
            if (!hit && c > 20000) begin
                $display("wrong value wait %0d expected event seen none", sel);
                fails++;
                wrap_up();
            end
        end
    endtask

    task automatic t_reset();
        logic [7:0] d;
        rd(`SWT_ADDR_IRQ_CTRL, d);
        chk("irq_ctrl reset", 16'h0000, {8'h00, d});
        rd(`SWT_ADDR_CTRL, d);
        chk("ctrl reset", 16'h0070, {8'h00, d});
        chk("view reset", 16'h0000, view);
    endtask

    task automatic t_regs();
        logic [7:0] d;
        wr(`SWT_ADDR_IRQ_CTRL, 8'hFF);
        rd(`SWT_ADDR_IRQ_CTRL, d);
        chk("irq_ctrl ones", 16'h0030, {8'h00, d});
        wr(`SWT_ADDR_IRQ_CTRL, 8'h00);
        wr(`SWT_ADDR_CTRL, 8'hFF);
        rd(`SWT_ADDR_CTRL, d);
        chk("ctrl ones", 16'h0073, {8'h00, d});
        rd(8'hA0, d);
        chk("unmapped", 16'h0000, {8'h00, d});
        wr(`SWT_ADDR_CTRL, 8'h70);
    endtask

    task automatic t_delays();
        int tbl[8] = '{4, 6, 8, 12, 16, 24, 32, 48};
        int c;
        period = 16'h003C;
        for (int k = 0; k < 8; k++) begin
            wr(`SWT_ADDR_CTRL, 8'(k << 4));
            wait_for(0, c);
            wait_for(1, c);
            chk("second delay", 16'(tbl[k] * DIV), 16'(c));
        end
        wr(`SWT_ADDR_CTRL, 8'h70);
    endtask

    task automatic t_period();
        int c;
        wait_for(0, c);
        wait_for(0, c);
        chk("period res0", 16'(60 * DIV), 16'(c));
        period = 16'h0002;
        wr(`SWT_ADDR_CTRL, 8'h75);
        wait_for(0, c);
        wait_for(0, c);
        chk("period res1", 16'(64 * DIV), 16'(c));
        period = 16'h003C;
        wr(`SWT_ADDR_CTRL, 8'h70);
    endtask

    // The quiet gap after a second event leaves room for the flag sequence
    task automatic t_irq();
        logic [7:0] d;
        int c;
        wait_for(1, c);
        rd(`SWT_ADDR_IRQ_CTRL, d);
        chk("flags set", 16'h0003, {8'h00, d});
        chk("irq masked", 16'h0000, {15'h0, irq});
        wr(`SWT_ADDR_IRQ_CTRL, 8'h13);
        chk("irq en0", 16'h0001, {15'h0, irq});
        wr(`SWT_ADDR_IRQ_CTRL, 8'h12);
        chk("irq p0 cleared", 16'h0000, {15'h0, irq});
        wr(`SWT_ADDR_IRQ_CTRL, 8'h22);
        chk("irq en1", 16'h0001, {15'h0, irq});
        wr(`SWT_ADDR_IRQ_CTRL, 8'h20);
        chk("irq p1 cleared", 16'h0000, {15'h0, irq});
        rd(`SWT_ADDR_IRQ_CTRL, d);
        chk("flags cleared", 16'h0020, {8'h00, d});
    endtask

    // Flag clear lands on the very edge of a second event, which must win
    task automatic t_race();
        logic [7:0] d;
        int c;
        wait_for(0, c);
        repeat (48 * DIV - 2) @(negedge mclk);
        wr(`SWT_ADDR_IRQ_CTRL, 8'h00);
        chk("race event", 16'h0001, {15'h0, ev1});
        rd(`SWT_ADDR_IRQ_CTRL, d);
        chk("race flags", 16'h0002, {8'h00, d});
    endtask

    task automatic t_clear();
        logic [7:0] d;
        int c;
        wr(`SWT_ADDR_CTRL, 8'h74);
        @(negedge mclk);
        chk("view cleared", 16'h0000, view);
        rd(`SWT_ADDR_CTRL, d);
        chk("clear reads 0", 16'h0070, {8'h00, d});
        wait_for(2, c);
        wait_for(2, c);
        chk("tick spacing", 16'(DIV), 16'(c));
    endtask

    // Each switch lands well inside one tick, so the count must not move
    task automatic t_res();
        logic [15:0] v0;
        int c;
        repeat (1100 * DIV) @(negedge mclk);
        for (int r = 1; r < 4; r++) begin
            wait_for(2, c);
            v0 = view;
            wr(`SWT_ADDR_CTRL, 8'h70 | 8'(r));
            @(negedge mclk);
            chk("view window", v0 >> (5 * r), view);
            wr(`SWT_ADDR_CTRL, 8'h70);
            @(negedge mclk);
            chk("view restored", v0, view);
        end
    endtask

    initial begin
        fails     = 0;
        n_tests   = 0;
        rst_n     = 1'b0;
        req       = '0;
        period    = 16'h0000;
        repeat (10) @(negedge mclk);
        rst_n     = 1'b1;
        t_reset();
        t_regs();
        t_delays();
        t_period();
        t_irq();
        t_race();
        t_clear();
        t_res();
        wrap_up();
    end
endmodule
